// ### inc/pkr_pkg.sv
// package for the power key and reset control block
package pkr_pkg;

  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned KEY_HOLD_MS   = 2000;  // power key hold, least
  localparam int unsigned CMD_READY_MS  = 5000;  // command ready after key fall
  localparam int unsigned RST_HOLD_MS   = 50;    // reset hold, more than
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned KEY_HOLD_CYC  = KEY_HOLD_MS * CYC_PER_MS;
  localparam int unsigned CMD_READY_CYC = CMD_READY_MS * CYC_PER_MS;
  localparam int unsigned RST_HOLD_CYC  = RST_HOLD_MS * CYC_PER_MS + 1;
  localparam int unsigned CNT_W         = 30;

  // power states, one-hot
  typedef enum logic [4:0] {
    PKR_OFF   = 5'h01,
    PKR_INIT  = 5'h02,
    PKR_ON    = 5'h04,
    PKR_SHUT  = 5'h08,
    PKR_RESET = 5'h10
  } pkr_state_t;

  // synchronised control pins, both active low
  typedef struct packed {
    logic key_low;
    logic rst_low;
  } pkr_pins_t;

  // status toward the module core
  typedef struct packed {
    logic powered;
    logic cmd_ready;
    logic core_reset;
  } pkr_status_t;

endpackage

// ### design/pkr_sync.sv
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/100ps
module pkr_sync
  import pkr_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic pin_in,
  output logic      pin_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // pins idle high; reset to inactive so no false press is seen
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      s1_reg <= 1'h1;
      s2_reg <= 1'h1;
      s3_reg <= 1'h1;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // change counts only once stage two and three agree
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      pin_out <= 1'h1;
    else if (s2_reg == s3_reg)
      pin_out <= s3_reg;
  end

endmodule

// ### design/pkr_ctrl.sv
// power key and reset sequencer of the cellular module
`timescale 1ns/100ps
module pkr_ctrl
  import pkr_pkg::*;
#(
  parameter int unsigned KEY_CYC   = KEY_HOLD_CYC,
  parameter int unsigned READY_CYC = CMD_READY_CYC,
  parameter int unsigned RST_CYC   = RST_HOLD_CYC
)
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic power_key_low,
  input  wire logic reset_low,
  input  wire logic shutdown_cmd,
  input  wire logic shutdown_done,
  output logic      powered,
  output logic      cmd_ready,
  output logic      core_reset
);

  pkr_pins_t   pins;
  pkr_state_t  state_reg;
  pkr_state_t  state_next;
  pkr_status_t stat_next;
  logic [CNT_W-1:0] key_cnt_reg;
  logic [CNT_W-1:0] rst_cnt_reg;
  logic [CNT_W-1:0] rdy_cnt_reg;
  logic key_qual_reg;
  logic key_low_d_reg;
  logic key_release;
  logic rst_qual;

  // pins come from the host, outside this clock domain
  pkr_sync u_key_sync
  (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin_in  (power_key_low),
    .pin_out (pins.key_low)
  );

  pkr_sync u_rst_sync
  (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin_in  (reset_low),
    .pin_out (pins.rst_low)
  );

  // time key low
  // saturating count so a key held for ever does not wrap
  // a high synchronised level means released and clears the count
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || pins.key_low)
      key_cnt_reg <= '0;
    else if (key_cnt_reg != KEY_CYC[CNT_W-1:0])
      key_cnt_reg <= key_cnt_reg + 1'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      key_qual_reg <= 1'h0;
    else if (pins.key_low)
      key_qual_reg <= 1'h0;
    else if (key_cnt_reg == KEY_CYC[CNT_W-1:0])
      key_qual_reg <= 1'h1;
  end

  // delayed key level for release detection
  // resets to the idle high level so no false release follows reset
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      key_low_d_reg <= 1'h1;
    else
      key_low_d_reg <= pins.key_low;
  end

  // release after a qualified hold; toggles power state
  assign key_release = key_qual_reg & pins.key_low & ~key_low_d_reg;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn || pins.rst_low)
      rst_cnt_reg <= '0;
    else if (rst_cnt_reg != RST_CYC[CNT_W-1:0])
      rst_cnt_reg <= rst_cnt_reg + 1'h1;
  end

  assign rst_qual = (rst_cnt_reg == RST_CYC[CNT_W-1:0]);

  // ready timer from key press in off
  // held clear while the key is up in off, so the count of a short press clears again on its release
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || state_reg == PKR_SHUT || state_reg == PKR_RESET)
      rdy_cnt_reg <= '0;
    else if (state_reg == PKR_OFF && pins.key_low && !key_release)
      rdy_cnt_reg <= '0;
    else if (rdy_cnt_reg != READY_CYC[CNT_W-1:0])
      rdy_cnt_reg <= rdy_cnt_reg + 1'h1;
  end

  // power state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PKR_OFF:
        if (key_release)
          state_next = PKR_INIT;
      PKR_INIT:
        if (rst_qual)
          state_next = PKR_RESET;
        else if (key_release)
          state_next = PKR_SHUT;
        else if (rdy_cnt_reg == READY_CYC[CNT_W-1:0])
          state_next = PKR_ON;
      PKR_ON:
        if (rst_qual)
          state_next = PKR_RESET;
        else if (key_release)
          state_next = PKR_SHUT;
        else if (shutdown_cmd)
          state_next = PKR_SHUT;
      PKR_SHUT:
        if (shutdown_done)
          state_next = (!pins.key_low) ? PKR_INIT : PKR_OFF;
      PKR_RESET:
        if (pins.rst_low)
          state_next = PKR_INIT;
      default:
        state_next = PKR_OFF;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      state_reg <= PKR_OFF;
    else
      state_reg <= state_next;
  end

  // status outputs decoded from next state, registered
  always_comb
  begin
    stat_next.powered    = (state_next != PKR_OFF);
    stat_next.cmd_ready  = (state_next == PKR_ON);
    stat_next.core_reset = (state_next == PKR_RESET);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      powered    <= 1'h0;
      cmd_ready  <= 1'h0;
      core_reset <= 1'h0;
    end
    else
    begin
      powered    <= stat_next.powered;
      cmd_ready  <= stat_next.cmd_ready;
      core_reset <= stat_next.core_reset;
    end
  end

  // assertions
  sequence s_on_press;
    state_reg == PKR_OFF && key_release;
  endsequence

  property p_power_on;
    @(posedge ref_clk) disable iff (!resetn)
    s_on_press |=> state_reg == PKR_INIT ##1 powered;
  endproperty
  a_power_on: assert property (p_power_on) else $error("power-on not started");

  property p_short_ignored;
    @(posedge ref_clk) disable iff (!resetn)
    key_release |-> $past(key_cnt_reg) == KEY_CYC[CNT_W-1:0];
  endproperty
  a_short_ignored: assert property (p_short_ignored) else $error("short press acted");

  property p_ready_time;
    @(posedge ref_clk) disable iff (!resetn)
    $rose(cmd_ready) |-> $past(rdy_cnt_reg) == READY_CYC[CNT_W-1:0];
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("ready early");

  property p_no_cmd_init;
    @(posedge ref_clk) disable iff (!resetn)
    state_reg == PKR_INIT |-> !cmd_ready;
  endproperty
  a_no_cmd_init: assert property (p_no_cmd_init) else $error("ready in init");

  property p_key_off;
    @(posedge ref_clk) disable iff (!resetn)
    state_reg == PKR_ON && !rst_qual && key_release |=> state_reg == PKR_SHUT ##1 !cmd_ready;
  endproperty
  a_key_off: assert property (p_key_off) else $error("key shutdown missed");

  property p_cmd_off;
    @(posedge ref_clk) disable iff (!resetn)
    state_reg == PKR_ON && !rst_qual && shutdown_cmd |=> state_reg == PKR_SHUT;
  endproperty
  a_cmd_off: assert property (p_cmd_off) else $error("command shutdown missed");

  property p_restart;
    @(posedge ref_clk) disable iff (!resetn)
    state_reg == PKR_SHUT && shutdown_done && !pins.key_low |=> state_reg == PKR_INIT;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on low key");

  property p_reset;
    @(posedge ref_clk) disable iff (!resetn)
    state_reg == PKR_ON && rst_qual |=> core_reset;
  endproperty
  a_reset: assert property (p_reset) else $error("reset not applied");

endmodule

// ### testbench/pkr_host.sv
// host model that drives the power key and reset pins of the sequencer
`timescale 1ns/100ps
module pkr_host
  import pkr_pkg::*;
(
  input  wire logic ref_clk,
  output logic      power_key_low,
  output logic      reset_low
);
  // both pins idle high, like a released button with its pull-up
  initial
  begin
    power_key_low = 1'b1;
    reset_low     = 1'b1;
  end

  // key hold time
  // key held low for n cycles then released; the length decides whether it acts
  task automatic press(input int n);
    @(negedge ref_clk) power_key_low = 1'b0;
    repeat (n) @(negedge ref_clk);
    power_key_low = 1'b1;
  endtask

  // key level
  // key set to a level and left there, for a restart after a command shutdown
  task automatic key_level(input logic v);
    @(negedge ref_clk) power_key_low = v;
  endtask

  // reset pulse
  // reset held low for n cycles; the bench pulses it after first switch-on
  task automatic rst(input int n);
    @(negedge ref_clk) reset_low = 1'b0;
    repeat (n) @(negedge ref_clk);
    reset_low = 1'b1;
  endtask

  // supply kept
  // the supply is never dropped here, so only key or command ends a session
endmodule

// ### testbench/test_module_power_key_and_reset_control.sv
// self-checking bench for the power key and reset sequencer
`timescale 1ns/100ps
module test_module_power_key_and_reset_control
  import pkr_pkg::*;
;
  localparam int unsigned K  = 20;
  localparam int unsigned R  = 50;
  localparam int unsigned S  = 6;
  localparam int          PW = 2;
  localparam int          RD = 1;
  localparam int          CR = 0;

  logic        ref_clk;
  logic        resetn;
  logic        power_key_low;
  logic        reset_low;
  logic        shutdown_cmd;
  logic        shutdown_done;
  pkr_status_t st;
  int          error_cnt;
  int          checked;

  pkr_host host (.ref_clk(ref_clk), .power_key_low(power_key_low), .reset_low(reset_low));

  // shortened counts keep the run to a few hundred cycles
  pkr_ctrl #(.KEY_CYC(K), .READY_CYC(R), .RST_CYC(S)) uut (
    .ref_clk      (ref_clk),
    .resetn       (resetn),
    .power_key_low(power_key_low),
    .reset_low    (reset_low),
    .shutdown_cmd (shutdown_cmd),
    .shutdown_done(shutdown_done),
    .powered      (st.powered),
    .cmd_ready    (st.cmd_ready),
    .core_reset   (st.core_reset)
  );

  initial
  begin
    ref_clk = 1'b0;
  end
  always #5 ref_clk = ~ref_clk;

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // bounded wait for one status bit; running out ends the run
  task automatic wait_st(input int sel, input logic v, input int bound, input string msg);
    int i;
    for (i = 0; i < bound; i++)
    begin
      @(negedge ref_clk);
      if (st[sel] === v)
        break;
    end
    chk(st[sel], v, msg);
    if (st[sel] !== v)
      test_done();
  endtask

  // one-cycle pulse on command (0) or done (1)
  task automatic pulse(input int which);
    @(negedge ref_clk);
    if (which == 0)
      shutdown_cmd = 1'b1;
    else
      shutdown_done = 1'b1;
    @(negedge ref_clk);
    shutdown_cmd  = 1'b0;
    shutdown_done = 1'b0;
  endtask

  task automatic t_short;
    host.press(K / 2);
    repeat (40) @(negedge ref_clk);
    chk(st[PW], 1'b0, "short press switched on");
    pulse(0);
    repeat (6) @(negedge ref_clk);
    chk(st[PW], 1'b0, "command while off acted");
    $display("short press test done");
  endtask

  task automatic t_on;
    host.press(K + 4);
    wait_st(PW, 1'b1, 30, "no power-on after long press");
    repeat (R - K - 10) @(negedge ref_clk);
    chk(st[RD], 1'b0, "commands open during init");
    wait_st(RD, 1'b1, 15, "command interface never ready");
    $display("power-on test done");
  endtask

  task automatic t_rst;
    host.rst(S / 2);
    repeat (20) @(negedge ref_clk);
    chk(st[CR], 1'b0, "short reset pulse acted");
    host.rst(S + 8);
    wait_st(CR, 1'b1, 30, "no system reset");
    wait_st(CR, 1'b0, 30, "system reset stuck");
    wait_st(RD, 1'b1, R + 40, "no ready after reset");
    $display("reset test done");
  endtask

  task automatic t_cmd_off;
    pulse(0);
    wait_st(RD, 1'b0, 10, "command shutdown not taken");
    chk(st[PW], 1'b1, "off before housekeeping");
    pulse(1);
    wait_st(PW, 1'b0, 10, "still on after command shutdown");
    $display("command shutdown test done");
  endtask

  task automatic t_key_off;
    host.press(K + 4);
    wait_st(RD, 1'b0, 30, "key shutdown not taken");
    pulse(1);
    wait_st(PW, 1'b0, 10, "still on after key shutdown");
    $display("key shutdown test done");
  endtask

  // key kept low through the end of a command shutdown, but shorter than a press
  task automatic t_restart;
    pulse(0);
    wait_st(RD, 1'b0, 10, "command shutdown not taken");
    host.key_level(1'b0);
    repeat (8) @(negedge ref_clk);
    pulse(1);
    repeat (4) @(negedge ref_clk);
    host.key_level(1'b1);
    repeat (10) @(negedge ref_clk);
    chk(st[PW], 1'b1, "no restart with key low");
    wait_st(RD, 1'b1, R + 40, "no ready after restart");
    $display("restart test done");
  endtask

  initial
  begin
    error_cnt     = 0;
    checked       = 0;
    resetn        = 1'b0;
    shutdown_cmd  = 1'b0;
    shutdown_done = 1'b0;
    repeat (16) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    chk(st[PW], 1'b0, "on out of reset");
    t_short();
    t_on();
    t_rst();
    t_cmd_off();
    t_on();
    t_key_off();
    t_on();
    t_restart();
    test_done();
  end
endmodule
